// >>> core/word_array_compare_move.sv
// sequencer for the compare_word_arrays and move_word_array instructions
`include "word_array_params.svh"
module word_array_compare_move (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        start_in,
  input  wire logic        op_move_in,
  input  wire logic [15:0] pc_in,
  input  wire logic [15:0] acc_a_in,
  input  wire logic [15:0] acc_b_in,
  input  wire logic        int_pending_in,
  input  wire logic [15:0] mem_rdata_in,
  input  wire logic        mem_ack_in,
  input  wire logic        mem_prot_fail_in,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [15:0]      mem_addr_out,
  output logic [15:0]      mem_wdata_out,
  output logic             busy_out,
  output logic             done_out,
  output logic             interrupted_out,
  output logic             prot_fault_out,
  output logic [1:0]       exit_out,
  output logic [15:0]      acc_a_out,
  output logic [15:0]      acc_b_out,
  output logic [15:0]      pc_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  word_array_pkg::state_t state;
  word_array_pkg::op_t    op;
  logic [15:0]            pc;
  logic [15:0]            w2_ptr;
  logic [15:0]            remaining;
  logic [15:0]            src_word;
  logic                   resumed;
  logic                   finishing;
  logic                   fault;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic        mem_state;
  wire logic        xfer;
  wire logic [15:0] acc_a_inc;
  wire logic [15:0] acc_b_inc;
  wire logic [15:0] rem_dec;
  wire logic        last_elem;
  wire logic        words_equal;
  wire logic        a_less;
  wire logic [15:0] req_addr;
  wire logic        req_we;
  wire logic [15:0] req_wdata;
  wire logic        hit_acc_a;
  wire logic        hit_acc_b;
  wire logic [15:0] a_masked_in;
  wire logic [15:0] b_masked_in;

  assign mem_state = (state == word_array_pkg::ST_W2)
                   | (state == word_array_pkg::ST_W3)
                   | (state == word_array_pkg::ST_CNT)
                   | (state == word_array_pkg::ST_SRC)
                   | (state == word_array_pkg::ST_DST)
                   | (state == word_array_pkg::ST_WR)
                   | (state == word_array_pkg::ST_SAVE);
  assign xfer = mem_req_out & mem_ack_in;

  // wrap inside the low 15 bits; bit 15 is carried through untouched
  assign acc_a_inc = {acc_a_out[`ADDR_LOW_W],
                      acc_a_out[`ADDR_LOW_W-1:0]
                      + `ADDR_LOW_W'(`ONE_W)};               // RULE16
  assign acc_b_inc = {acc_b_out[`ADDR_LOW_W],
                      acc_b_out[`ADDR_LOW_W-1:0]
                      + `ADDR_LOW_W'(`ONE_W)};               // RULE16
  assign rem_dec   = remaining - `ONE_W;
  assign last_elem = (rem_dec == `ZERO_W);

  assign words_equal = (src_word == mem_rdata_in);
  assign a_less      = $signed(src_word) < $signed(mem_rdata_in); // RULE3

  assign a_masked_in = acc_a_in & `ADDR_MASK;                  // RULE1
  assign b_masked_in = acc_b_in & `ADDR_MASK;                  // RULE1

  // destination 0 or 1 is the accumulator pair, not memory
  assign hit_acc_a = ((acc_b_out & `ADDR_MASK) == `ACC_A_ADDR); // RULE16
  assign hit_acc_b = ((acc_b_out & `ADDR_MASK) == `ACC_B_ADDR); // RULE16

  assign req_addr =
      (state == word_array_pkg::ST_W2)  ? pc + `W2_OFS :
      (state == word_array_pkg::ST_W3)  ? pc + `W3_OFS :
      (state == word_array_pkg::ST_CNT) ? w2_ptr & `ADDR_MASK : // RULE18
      (state == word_array_pkg::ST_SRC) ? acc_a_out & `ADDR_MASK :
      (state == word_array_pkg::ST_DST) ? acc_b_out & `ADDR_MASK :
      (state == word_array_pkg::ST_WR)  ? acc_b_out & `ADDR_MASK :
                                          pc + `W3_OFS;         // RULE9
  assign req_we    = (state == word_array_pkg::ST_WR)
                   | (state == word_array_pkg::ST_SAVE);
  // a finished resumed instruction leaves word 3 zero again
  assign req_wdata = (state == word_array_pkg::ST_WR) ? src_word :
                     finishing ? `ZERO_W : remaining;           // RULE10

  // ---------------------------------------------------------------
  // memory handshake: request held until acknowledged
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= `ZERO_W;
      mem_wdata_out <= `ZERO_W;
    end
    else if (xfer)
    begin
      mem_req_out <= 1'b0;
      mem_we_out  <= 1'b0;
    end
    else if (mem_state && !mem_req_out &&
             !(state == word_array_pkg::ST_WR && (hit_acc_a || hit_acc_b)))
    begin
      mem_req_out   <= 1'b1;
      mem_we_out    <= req_we;
      mem_addr_out  <= req_addr;
      mem_wdata_out <= req_wdata;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      state           <= word_array_pkg::ST_IDLE;
      op              <= word_array_pkg::OP_COMPARE;
      pc              <= `ZERO_W;
      w2_ptr          <= `ZERO_W;
      remaining       <= `ZERO_W;
      src_word        <= `ZERO_W;
      resumed         <= 1'b0;
      finishing       <= 1'b0;
      fault           <= 1'b0;
      busy_out        <= 1'b0;
      done_out        <= 1'b0;
      interrupted_out <= 1'b0;
      prot_fault_out  <= 1'b0;
      exit_out        <= word_array_pkg::EXIT_EQ;
      acc_a_out       <= `ZERO_W;
      acc_b_out       <= `ZERO_W;
      pc_out          <= `ZERO_W;
    end
    else
    begin
      done_out <= 1'b0;
      unique case (state)
        word_array_pkg::ST_IDLE:
        begin
          if (start_in)
          begin
            op        <= op_move_in ? word_array_pkg::OP_MOVE
                                    : word_array_pkg::OP_COMPARE;
            pc        <= pc_in;
            // move keeps bit 15; compare drops it
            acc_a_out <= op_move_in ? acc_a_in : a_masked_in; // RULE13
            acc_b_out <= op_move_in ? acc_b_in : b_masked_in; // RULE13
            resumed   <= 1'b0;
            finishing <= 1'b0;
            fault     <= 1'b0;
            busy_out  <= 1'b1;
            state     <= word_array_pkg::ST_W2;
          end
        end
        word_array_pkg::ST_W2:
        begin
          if (xfer)
          begin
            w2_ptr <= mem_rdata_in;
            state  <= word_array_pkg::ST_W3;
          end
        end
        word_array_pkg::ST_W3:
        begin
          if (xfer)
          begin
            if (mem_rdata_in != `ZERO_W)
            begin
              remaining <= mem_rdata_in;                        // RULE19
              resumed   <= 1'b1;
              state     <= word_array_pkg::ST_SRC;
            end
            else
            begin
              state <= word_array_pkg::ST_CNT;
            end
          end
        end
        word_array_pkg::ST_CNT:
        begin
          if (xfer)
          begin
            remaining <= mem_rdata_in;                 // RULE2 RULE14
            state     <= word_array_pkg::ST_SRC;
          end
        end
        word_array_pkg::ST_SRC:
        begin
          if (xfer)
          begin
            src_word <= mem_rdata_in;                           // RULE12
            state    <= (op == word_array_pkg::OP_MOVE)
                        ? word_array_pkg::ST_WR
                        : word_array_pkg::ST_DST;
          end
        end
        word_array_pkg::ST_DST:
        begin
          if (xfer)
          begin
            if (!words_equal)
            begin
              // stop address stays in the first accumulator
              exit_out  <= a_less ? word_array_pkg::EXIT_LT
                                  : word_array_pkg::EXIT_GT;     // RULE4
              pc_out    <= a_less ? pc + `EXIT_LT_OFS
                                  : pc + `EXIT_GT_OFS;     // RULE6 RULE7
              acc_b_out <= acc_b_out + remaining;               // RULE8
              finishing <= 1'b1;
              state     <= resumed ? word_array_pkg::ST_SAVE
                                   : word_array_pkg::ST_DONE;
            end
            else
            begin
              acc_a_out <= acc_a_inc;
              acc_b_out <= acc_b_inc;
              remaining <= rem_dec;
              if (last_elem)
              begin
                exit_out  <= word_array_pkg::EXIT_EQ;           // RULE4
                pc_out    <= pc + `EXIT_EQ_OFS;                 // RULE5
                finishing <= 1'b1;
                state     <= resumed ? word_array_pkg::ST_SAVE
                                     : word_array_pkg::ST_DONE;
              end
              else if (int_pending_in)
              begin
                state <= word_array_pkg::ST_SAVE;               // RULE9
              end
              else
              begin
                state <= word_array_pkg::ST_SRC;
              end
            end
          end
        end
        word_array_pkg::ST_WR:
        begin
          // a write aimed at an accumulator lands there, then steps
          if (hit_acc_a || hit_acc_b || xfer)
          begin
            if (xfer && mem_prot_fail_in)
            begin
              fault <= 1'b1;                                    // RULE17
              state <= word_array_pkg::ST_SAVE;
            end
            else
            begin
              acc_a_out <= hit_acc_a ? src_word + `ONE_W
                                     : acc_a_inc;        // RULE15 RULE16
              acc_b_out <= hit_acc_b ? src_word + `ONE_W
                                     : acc_b_inc;        // RULE15 RULE16
              remaining <= rem_dec;
              if (last_elem)
              begin
                pc_out    <= pc + `EXIT_EQ_OFS;
                exit_out  <= word_array_pkg::EXIT_EQ;
                finishing <= 1'b1;
                state     <= resumed ? word_array_pkg::ST_SAVE
                                     : word_array_pkg::ST_DONE;
              end
              else if (int_pending_in)
              begin
                state <= word_array_pkg::ST_SAVE;               // RULE9
              end
              else
              begin
                state <= word_array_pkg::ST_SRC;
              end
            end
          end
        end
        word_array_pkg::ST_SAVE:
        begin
          if (xfer)
          begin
            if (!finishing)
            begin
              pc_out <= pc;                                     // RULE9
            end
            state <= word_array_pkg::ST_DONE;
          end
        end
        word_array_pkg::ST_DONE:
        begin
          done_out        <= 1'b1;
          busy_out        <= 1'b0;
          interrupted_out <= !finishing && !fault;
          prot_fault_out  <= fault;
          state           <= word_array_pkg::ST_IDLE;
        end
        default:
        begin
          state <= word_array_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> core/word_array_params.svh
// constants for the word array compare and move sequencer
// Function
// RULE1: compare addresses from accumulators, bit 15 ignored
// RULE2: compare count fetched via word 2, nonzero
// RULE3: elements compared as signed 16-bit values
// RULE4: first unequal pair decides; equal needs all
// RULE5: equal exit skips none, first accumulator advanced
// RULE6: less exit skips one, stop address kept
// RULE7: greater exit skips two, stop address kept
// RULE8: second accumulator always ends start plus count
// RULE9: interruptible; remaining count saved in word 3
// RULE10: three-word instruction, word 3 issued zero
// RULE11: software avoids both under code/data separation
// RULE12: move copies lowest address first
// RULE13: move source first, destination second accumulator
// RULE14: move count 16-bit nonzero via word 2
// RULE15: both accumulators step per moved element
// RULE16: addresses wrap at bit 15; low targets hit accumulators
// RULE17: protection checked on every element write
// RULE18: move count fetched through word 2 address
// RULE19: nonzero word 3 resumes with remaining count
`ifndef WORD_ARRAY_PARAMS_SVH
`define WORD_ARRAY_PARAMS_SVH
`define ADDR_MASK    16'h7fff
`define ADDR_LOW_W   15
`define W2_OFS       16'h0001
`define W3_OFS       16'h0002
`define EXIT_EQ_OFS  16'h0003
`define EXIT_LT_OFS  16'h0004
`define EXIT_GT_OFS  16'h0005
`define ONE_W        16'h0001
`define ZERO_W       16'h0000
`define ACC_A_ADDR   16'h0000
`define ACC_B_ADDR   16'h0001
`endif

// >>> core/word_array_pkg.sv
// types shared by the word array sequencer
package word_array_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_W2   = 4'b0001,
    ST_W3   = 4'b0010,
    ST_CNT  = 4'b0011,
    ST_SRC  = 4'b0100,
    ST_DST  = 4'b0101,
    ST_WR   = 4'b0110,
    ST_SAVE = 4'b0111,
    ST_DONE = 4'b1000
  } state_t;
  typedef enum logic {
    OP_COMPARE = 1'b0,
    OP_MOVE    = 1'b1
  } op_t;
  typedef enum logic [1:0] {
    EXIT_EQ = 2'b00,
    EXIT_LT = 2'b01,
    EXIT_GT = 2'b10
  } exit_t;
endpackage

// >>> tb/word_array_compare_move_chk.sv
// port-level checks for the word array sequencer
module word_array_compare_move_chk (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        start_in,
  input wire logic        mem_ack_in,
  input wire logic        mem_prot_fail_in,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] mem_wdata_out,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic        interrupted_out,
  input wire logic        prot_fault_out,
  input wire logic [1:0]  exit_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  req_hold_a: assert property (mem_req_out && !mem_ack_in |=>
    mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out)
    && (!mem_we_out || $stable(mem_wdata_out))) else $error("req moved");
  req_drop_a: assert property (mem_req_out && mem_ack_in |=>
    !mem_req_out) else $error("req held past ack");
  first_read_a: assert property (start_in && !busy_out |->
    ##[1:2] mem_req_out && !mem_we_out) else $error("no first read");
  done_pulse_a: assert property (done_out |=>
    !done_out && !busy_out) else $error("done not a pulse");
  idle_quiet_a: assert property (!busy_out |->
    !mem_req_out) else $error("request while idle");
  exit_legal_a: assert property (done_out |->
    exit_out != 2'h3) else $error("bad exit code");
  prot_stop_a: assert property (mem_req_out && mem_we_out
    && mem_ack_in && mem_prot_fail_in |-> ##[1:40]
    done_out && prot_fault_out) else $error("fault not stopped");
  int_flag_a: assert property ($rose(interrupted_out) |->
    done_out) else $error("interrupt flag off done");
endmodule
bind word_array_compare_move word_array_compare_move_chk
  i_word_array_compare_move_chk (.*);

// >>> tb/word_array_mem_model.sv
// main memory with adjustable wait and one protected address
module word_array_mem_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [1:0]  wait_in,
  input  wire logic [15:0] prot_addr_in,
  output logic             ack_out,
  output logic             prot_fail_out,
  output logic [15:0]      rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:1023];
  int          cnt = 0;
  initial
  begin
    ack_out = 1'b0;
    prot_fail_out = 1'b0;
    rdata_out = 16'h0000;
  end
  always @(posedge clk_in)
  begin
    ack_out <= 1'b0;
    prot_fail_out <= 1'b0;
    // read data is inverted on every cycle without a read ack, so outside the ack it looks valid on alternate cycles
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out)
    begin
      if (cnt < wait_in)
        cnt <= cnt + 1;
      else
      begin
        cnt <= 0;
        ack_out <= 1'b1;
        if (!we_in)
          rdata_out <= mem[addr_in[9:0]];
        else if (addr_in == prot_addr_in)
          prot_fail_out <= 1'b1;
        else
          mem[addr_in[9:0]] <= wdata_in;
      end
    end
  end
endmodule

// >>> tb/word_array_compare_move_tb.sv
// self-checking bench for the word array sequencer
module word_array_compare_move_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        start_in = 1'b0;
  logic        op_move_in = 1'b0;
  logic        int_pending_in = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [15:0] acc_a_in = 16'h0000;
  logic [15:0] acc_b_in = 16'h0000;
  logic [1:0]  wait_cyc = 2'h0;
  logic [15:0] prot_addr = 16'hffff;
  logic        mem_req_out, mem_we_out, mem_ack_in, mem_prot_fail_in;
  logic        busy_out, done_out, interrupted_out, prot_fault_out;
  logic [15:0] mem_addr_out, mem_wdata_out, mem_rdata_in;
  logic [15:0] acc_a_out, acc_b_out, pc_out;
  logic [1:0]  exit_out;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  word_array_compare_move i_word_array_compare_move (.*);
  word_array_mem_model i_word_array_mem_model (.clk_in,
    .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .wait_in(wait_cyc), .prot_addr_in(prot_addr),
    .ack_out(mem_ack_in), .prot_fail_out(mem_prot_fail_in),
    .rdata_out(mem_rdata_in));
  initial
  begin
    forever #2 clk_in = ~clk_in;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [15:0] ad, d);
    i_word_array_mem_model.mem[ad[9:0]] = d;
  endtask
  function automatic logic [15:0] peek(input logic [15:0] ad);
    return i_word_array_mem_model.mem[ad[9:0]];
  endfunction
  // count sits 16 words past the instruction, word 3 issued zero
  task automatic prep(input logic [15:0] pc, cnt);
    put(pc + 16'h0001, pc + 16'h0010);
    put(pc + 16'h0002, 16'h0000);
    put(pc + 16'h0010, cnt);
  endtask
  task automatic go(input logic op, input logic [15:0] pc, a, b);
    @(negedge clk_in);
    op_move_in = op;
    pc_in = pc;
    acc_a_in = a;
    acc_b_in = b;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    while (done_out !== 1'b1)
      @(negedge clk_in);
  endtask
  task automatic ends(input logic [15:0] pc, a, b);
    check("pc", pc_out, pc);
    check("acc a", acc_a_out, a);
    check("acc b", acc_b_out, b);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic cmp_equal();
    prep(16'h0040, 16'h0003);
    for (int i = 0; i < 3; i++)
    begin
      put(16'h0100 + 16'(i), 16'h8000 + 16'(i));
      put(16'h0180 + 16'(i), 16'h8000 + 16'(i));
    end
    go(1'b0, 16'h0040, 16'h8100, 16'h8180);
    check("exit", {14'h0000, exit_out}, 16'h0000);
    ends(16'h0043, 16'h0103, 16'h0183);
  endtask
  // second pair differs; signed order differs from unsigned
  task automatic cmp_signed();
    logic [15:0] xs [2] = '{16'hffff, 16'h7fff};
    logic [15:0] ys [2] = '{16'h0001, 16'h8000};
    for (int k = 0; k < 2; k++)
    begin
      prep(16'h0040, 16'h0003);
      put(16'h0101, xs[k]);
      put(16'h0181, ys[k]);
      go(1'b0, 16'h0040, 16'h0100, 16'h0180);
      check("exit", {14'h0000, exit_out}, 16'(k + 1));
      ends(16'h0044 + 16'(k), 16'h0101, 16'h0183);
    end
  endtask
  // stopped after the first pair, then resumed to the equal exit
  task automatic cmp_interrupt();
    prep(16'h0040, 16'h0003);
    put(16'h0101, 16'h8001);
    put(16'h0181, 16'h8001);
    int_pending_in = 1'b1;
    go(1'b0, 16'h0040, 16'h0100, 16'h0180);
    int_pending_in = 1'b0;
    check("intr", {15'h0000, interrupted_out}, 16'h0001);
    check("word3", peek(16'h0042), 16'h0002);
    ends(16'h0040, 16'h0101, 16'h0181);
    go(1'b0, 16'h0040, acc_a_out, acc_b_out);
    check("exit", {14'h0000, exit_out}, 16'h0000);
    check("word3", peek(16'h0042), 16'h0000);
    ends(16'h0043, 16'h0103, 16'h0183);
  endtask
  task automatic mv_overlap();
    wait_cyc = 2'h2;
    prep(16'h0060, 16'h0004);
    put(16'h0200, 16'h1234);
    go(1'b1, 16'h0060, 16'h0200, 16'h0201);
    for (int i = 1; i < 5; i++)
      check("dest", peek(16'h0200 + 16'(i)), 16'h1234);
    check("word3", peek(16'h0062), 16'h0000);
    ends(16'h0063, 16'h0204, 16'h0205);
    wait_cyc = 2'h0;
  endtask
  task automatic mv_wrap();
    prep(16'h0060, 16'h0001);
    put(16'h7fff, 16'h0abc);
    go(1'b1, 16'h0060, 16'h7fff, 16'h0300);
    check("dest", peek(16'h0300), 16'h0abc);
    ends(16'h0063, 16'h0000, 16'h0301);
  endtask
  // destination 1 is the second accumulator: memory stays untouched
  task automatic mv_low_dest();
    prep(16'h0060, 16'h0001);
    put(16'h0120, 16'h0500);
    put(16'h0001, 16'h0000);
    go(1'b1, 16'h0060, 16'h0120, 16'h0001);
    check("mem1", peek(16'h0001), 16'h0000);
    ends(16'h0063, 16'h0121, 16'h0501);
  endtask
  task automatic mv_interrupt();
    prep(16'h0070, 16'h0003);
    put(16'h0220, 16'h0011);
    put(16'h0221, 16'h0033);
    put(16'h0222, 16'h0055);
    int_pending_in = 1'b1;
    go(1'b1, 16'h0070, 16'h0220, 16'h0240);
    int_pending_in = 1'b0;
    check("intr", {15'h0000, interrupted_out}, 16'h0001);
    check("word3", peek(16'h0072), 16'h0002);
    check("dest", peek(16'h0240), 16'h0011);
    ends(16'h0070, 16'h0221, 16'h0241);
    go(1'b1, 16'h0070, acc_a_out, acc_b_out);
    check("intr", {15'h0000, interrupted_out}, 16'h0000);
    check("word3", peek(16'h0072), 16'h0000);
    check("dest", peek(16'h0241), 16'h0033);
    check("dest", peek(16'h0242), 16'h0055);
    ends(16'h0073, 16'h0223, 16'h0243);
  endtask
  task automatic mv_protect();
    prep(16'h0080, 16'h0003);
    put(16'h0250, 16'h0a0a);
    put(16'h0251, 16'h0b0b);
    put(16'h0261, 16'h0000);
    prot_addr = 16'h0261;
    go(1'b1, 16'h0080, 16'h0250, 16'h0260);
    check("fault", {15'h0000, prot_fault_out}, 16'h0001);
    check("intr", {15'h0000, interrupted_out}, 16'h0000);
    check("pc", pc_out, 16'h0080);
    check("dest", peek(16'h0260), 16'h0a0a);
    check("guarded", peek(16'h0261), 16'h0000);
    check("word3", peek(16'h0082), 16'h0002);
    prot_addr = 16'hffff;
  endtask
  initial
  begin
    repeat (12) @(negedge clk_in);
    rst_b_in = 1'b1;
    cmp_equal();
    cmp_signed();
    cmp_interrupt();
    mv_overlap();
    mv_wrap();
    mv_low_dest();
    mv_interrupt();
    mv_protect();
    tally_and_finish();
  end
endmodule
